/* File: core/spe_entry.sv */
/*
 * programming-port entry logic: high-voltage and keyed low-voltage entry,
 * serial word capture in program/verify mode and data pin drive.
 * assumes: pins are asynchronous to ref_clk and slow against it (link clock
 * period 160 ns), hv level and reset-low detection come from analog
 * comparators as digital levels, the enable config bit is a static level.
 */
`timescale 1ns/1ps

module spe_entry #(
   parameter logic [spe_pkg::KEY_W-1:0] KEY    = spe_pkg::KEY_VALUE,
   parameter int                        WORD_W = spe_pkg::WORD_W
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              prog_clock_pin,
   input  wire logic              prog_data_pin_i,
   output logic                   prog_data_pin_o,
   output logic                   prog_data_pin_oe_n,
   input  wire logic              master_reset_pin,
   input  wire logic              reset_vpp_at_high_level,
   input  wire logic              low_voltage_entry_enable,
   input  wire logic              reset_pin_enable_setting,
   output logic                   reset_pin_enable,
   input  wire logic              enable_clear_req,
   output logic                   enable_clear_allow,
   output logic                   prog_mode,
   output logic                   hv_session,
   output logic                   lv_session,
   input  wire logic              tx_enable,
   input  wire logic              tx_bit,
   output logic      [WORD_W-1:0] rx_word,
   output logic                   rx_valid,
   input  wire logic              rx_ready,
   output logic                   rx_overrun
);
   localparam int CW = $clog2(WORD_W + 1);

   logic [spe_pkg::SYNC_W-1:0] pin_s1_q;
   logic [spe_pkg::SYNC_W-1:0] pin_s2_q;
   logic                       clk_prev_q;
   logic                       hv_prev_q;
   logic                       clk_s;
   logic                       dat_s;
   logic                       rst_high_s;
   logic                       hv_s;
   logic                       clk_rise;
   logic                       hv_rise;
   logic [spe_pkg::KEY_W-1:0]  key_sr_q;
   logic [5:0]                 key_cnt_q;
   logic                       key_match;
   logic                       hv_session_q;
   logic                       lv_session_q;
   logic [WORD_W-1:0]          word_sr_q;
   logic [CW-1:0]              word_cnt_q;
   logic                       word_valid_q;
   logic [WORD_W-1:0]          word_q;
   logic                       buf_in_ready;
   logic                       overrun_q;
   logic                       dat_out_q;
   logic                       oe_n_q;
   logic                       capture;

   // pins cross into ref_clk through two flops before any use
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_s1_q <= spe_pkg::SYNC_RESET;
         pin_s2_q <= spe_pkg::SYNC_RESET;
      end else begin
         pin_s1_q <= {reset_vpp_at_high_level, master_reset_pin,
                      prog_data_pin_i, prog_clock_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign clk_s      = pin_s2_q[spe_pkg::PIN_CLK];
   assign dat_s      = pin_s2_q[spe_pkg::PIN_DAT];
   assign rst_high_s = pin_s2_q[spe_pkg::PIN_RST];
   assign hv_s       = pin_s2_q[spe_pkg::PIN_HV];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_prev_q <= 1'b0;
         hv_prev_q  <= 1'b0;
      end else begin
         clk_prev_q <= clk_s;
         hv_prev_q  <= hv_s;
      end
   end

   assign clk_rise = clk_s & ~clk_prev_q;
   assign hv_rise  = hv_s & ~hv_prev_q;

   // high-voltage entry: both port pins must be low as the level arrives
   always_ff @(posedge ref_clk) begin
      if (rst || !hv_s) begin
         hv_session_q <= 1'b0;
      end else if (hv_rise && !clk_s && !dat_s) begin
         hv_session_q <= 1'b1;
      end
   end

   // key shifter, msb first on rising clock edges; cleared whenever the
   // reset pin is high or entry is disabled, so a partial key never lingers
   always_ff @(posedge ref_clk) begin
      if (rst || rst_high_s || !low_voltage_entry_enable) begin
         key_sr_q  <= '0;
         key_cnt_q <= '0;
      end else if (clk_rise && !prog_mode) begin
         key_sr_q <= {key_sr_q[spe_pkg::KEY_W-2:0], dat_s};
         if (key_cnt_q != spe_pkg::KEY_CNT_FULL) begin
            key_cnt_q <= key_cnt_q + 6'h01;
         end
      end
   end

   assign key_match = (key_cnt_q == spe_pkg::KEY_CNT_FULL) &&
                      (key_sr_q == KEY);

   // the session lives only while the reset pin stays low
   always_ff @(posedge ref_clk) begin
      if (rst || rst_high_s) begin
         lv_session_q <= 1'b0;
      end else if (key_match && low_voltage_entry_enable
                   && !hv_session_q) begin
         lv_session_q <= 1'b1;
      end
   end

   assign hv_session = hv_session_q;
   assign lv_session = lv_session_q;
   assign prog_mode  = hv_session_q | lv_session_q;
   assign reset_pin_enable   = reset_pin_enable_setting
                               | low_voltage_entry_enable;
   assign enable_clear_allow = enable_clear_req & hv_session_q
                               & ~lv_session_q;

   // word capture stalls while a finished word waits for buffer space;
   // the external clock cannot be held, so lost bits raise rx_overrun
   assign capture = prog_mode & clk_rise & ~tx_enable;

   always_ff @(posedge ref_clk) begin
      if (rst || !prog_mode) begin
         word_sr_q    <= '0;
         word_cnt_q   <= '0;
         word_valid_q <= 1'b0;
         word_q       <= '0;
      end else begin
         if (word_valid_q && buf_in_ready) begin
            word_valid_q <= 1'b0;
         end
         if (capture && !word_valid_q) begin
            if (word_cnt_q == CW'(WORD_W - 1)) begin
               word_q       <= {word_sr_q[WORD_W-2:0], dat_s};
               word_valid_q <= 1'b1;
               word_cnt_q   <= '0;
            end else begin
               word_sr_q  <= {word_sr_q[WORD_W-2:0], dat_s};
               word_cnt_q <= word_cnt_q + CW'(1);
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !prog_mode) begin
         overrun_q <= 1'b0;
      end else if (capture && word_valid_q) begin
         overrun_q <= 1'b1;
      end
   end

   assign rx_overrun = overrun_q;

   // data pin drive is registered; enable low means the pin is driven
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dat_out_q <= 1'b0;
         oe_n_q    <= 1'b1;
      end else begin
         dat_out_q <= tx_bit;
         oe_n_q    <= ~(prog_mode & tx_enable);
      end
   end

   assign prog_data_pin_o    = dat_out_q;
   assign prog_data_pin_oe_n = oe_n_q;

   spe_word_buffer #(
      .WIDTH (WORD_W),
      .DEPTH (spe_pkg::BUF_DEPTH)
   ) u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (word_q),
      .in_valid  (word_valid_q),
      .in_ready  (buf_in_ready),
      .out_data  (rx_word),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   hv_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(hv_session_q) |-> $past(hv_rise && !clk_s && !dat_s))
      else $error("hv session began without both port pins low");

   lv_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(lv_session_q) |-> $past(low_voltage_entry_enable))
      else $error("lv session began with entry disabled");

   lv_blocked_a: assert property (@(posedge ref_clk) disable iff (rst)
      !low_voltage_entry_enable |=> key_cnt_q == 6'h00 && key_sr_q == '0)
      else $error("key shifter active while entry disabled");

   key_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
      key_match && low_voltage_entry_enable && !rst_high_s && !hv_session_q
      |=> lv_session_q)
      else $error("valid key did not open lv session");

   reset_force_a: assert property (@(posedge ref_clk) disable iff (rst)
      low_voltage_entry_enable |-> reset_pin_enable)
      else $error("reset function not forced on");

   clear_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      enable_clear_allow |-> hv_session_q && !lv_session_q)
      else $error("enable clear allowed outside hv session");

   drive_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      !prog_data_pin_oe_n |-> $past(prog_mode && tx_enable))
      else $error("data pin driven outside program mode");

   key_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
      clk_rise && !prog_mode && !rst_high_s && low_voltage_entry_enable
      |=> key_sr_q[0] == $past(dat_s)
          && key_sr_q[spe_pkg::KEY_W-1:1]
             == $past(key_sr_q[spe_pkg::KEY_W-2:0]))
      else $error("key bit not shifted on rising clock edge");

   key_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      rst_high_s |=> key_cnt_q == 6'h00 && !lv_session_q)
      else $error("partial key survived reset pin high");
endmodule

/* File: core/spe_pkg.sv */
/*
 * constants shared by the serial programming entry block and its buffer.
 * assumes: one 100 MHz clock domain, synchronous active-high reset.
 */
package spe_pkg;
   localparam int          KEY_W        = 32;
   // key value is arbitrary; replace with the real entry key
   localparam logic [31:0] KEY_VALUE    = 32'h5a3c_96e1;
   localparam int          WORD_W       = 8;
   localparam int          BUF_DEPTH    = 2;
   localparam int          SYNC_W       = 4;
   localparam int          PIN_CLK      = 0;
   localparam int          PIN_DAT      = 1;
   localparam int          PIN_RST      = 2;
   localparam int          PIN_HV       = 3;
   localparam logic [3:0]  SYNC_RESET   = 4'h4;
   localparam logic [5:0]  KEY_CNT_FULL = 6'h20;
endpackage

/* File: core/spe_word_buffer.sv */
/*
 * small valid/ready buffer for received programming words.
 * assumes: same clock and reset as the entry logic; depth a power of two.
 */
`timescale 1ns/1ps
module spe_word_buffer #(
   parameter int WIDTH = spe_pkg::WORD_W,
   parameter int DEPTH = spe_pkg::BUF_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + AW'(1);
         end
         if (push && !pop) begin
            count_q <= count_q + (AW+1)'(1);
         end else if (pop && !push) begin
            count_q <= count_q - (AW+1)'(1);
         end
      end
   end

   buf_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      count_q <= (AW+1)'(DEPTH))
      else $error("word buffer holds more than its depth");
endmodule

/* File: test/spe_programmer.sv */
/*
 * behavioural programmer: drives clock, data, reset and hv pins.
 * assumes: bench ref_clk at 100 MHz; pins move on its falling edge.
 */
`timescale 1ns/1ps
module spe_programmer (
   input  wire logic ref_clk,
   input  wire logic dev_o,
   input  wire logic dev_oe_n,
   output logic      prog_clock_pin,
   output logic      data_w,
   output logic      master_reset_pin,
   output logic      reset_vpp_at_high_level
);
   logic drv;
   logic val;
   logic idl;
   initial begin
      prog_clock_pin = 1'b0;
      master_reset_pin = 1'b1;
      reset_vpp_at_high_level = 1'b0;
      drv = 1'b0;
      val = 1'b0;
      idl = 1'b0;
   end
   // an undriven line has no pull: toggle so a stale value never passes
   always @(negedge ref_clk) idl <= ~idl;
   assign data_w = !dev_oe_n ? dev_o : (drv ? val : idl);
   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // clock stands low between frames, 160 ns period within them
   task automatic send_bit(input logic b);
      drv = 1'b1;
      val = b;
      wait_n(8);
      prog_clock_pin = 1'b1;
      wait_n(8);
      prog_clock_pin = 1'b0;
   endtask
   task automatic send_key(input logic [31:0] k, input int hi, input int lo);
      for (int i = hi; i >= lo; i--) send_bit(k[i]);
      // release for one cycle so a following frame never re-drives at once
      drv = 1'b0;
      wait_n(1);
   endtask
   task automatic send_word(input logic [spe_pkg::WORD_W-1:0] w);
      for (int i = spe_pkg::WORD_W - 1; i >= 0; i--) send_bit(w[i]);
      drv = 1'b0;
      wait_n(1);
   endtask
   task automatic reset_low();
      master_reset_pin = 1'b0;
      wait_n(4);
   endtask
   task automatic reset_high();
      master_reset_pin = 1'b1;
      wait_n(6);
   endtask
   task automatic hv_enter(input logic dat);
      prog_clock_pin = 1'b0;
      drv = 1'b1;
      val = dat;
      wait_n(4);
      reset_vpp_at_high_level = 1'b1;
      wait_n(6);
   endtask
   task automatic hv_leave();
      reset_vpp_at_high_level = 1'b0;
      drv = 1'b0;
      wait_n(6);
   endtask
endmodule

/* File: test/tb.sv */
/*
 * self-checking bench for the programming entry logic.
 * assumes: spe_programmer as far side, 100 MHz ref_clk, sync reset.
 */
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] KEY = spe_pkg::KEY_VALUE;
   localparam int          WW  = spe_pkg::WORD_W;
   logic                          ref_clk = 1'b0;
   logic                          rst;
   logic                          en;
   logic                          set;
   logic                          clr_req;
   logic                          tx_en;
   logic                          tx_b;
   logic                          rdy;
   logic                          rdy_rand;
   logic                          rdy_hold;
   logic                          clk_pin;
   logic                          data_w;
   logic                          mrst;
   logic                          hv;
   logic                          pin_o;
   logic                          oe_n;
   logic                          rpe;
   logic                          allow;
   logic                          pm;
   logic                          hvs;
   logic                          lvs;
   logic                          rx_valid;
   logic                          ovr;
   logic [spe_pkg::WORD_W-1:0]    rx_word;
   logic [spe_pkg::WORD_W-1:0]    w;
   logic [spe_pkg::WORD_W-1:0]    exp_q[$];
   int                            n_fail = 0;
   int                            n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   spe_programmer i_prog (.ref_clk(ref_clk), .dev_o(pin_o), .dev_oe_n(oe_n),
      .prog_clock_pin(clk_pin), .data_w(data_w), .master_reset_pin(mrst),
      .reset_vpp_at_high_level(hv));
   spe_entry i_dut (.ref_clk(ref_clk), .rst(rst), .prog_clock_pin(clk_pin),
      .prog_data_pin_i(data_w), .prog_data_pin_o(pin_o),
      .prog_data_pin_oe_n(oe_n), .master_reset_pin(mrst),
      .reset_vpp_at_high_level(hv), .low_voltage_entry_enable(en),
      .reset_pin_enable_setting(set), .reset_pin_enable(rpe),
      .enable_clear_req(clr_req), .enable_clear_allow(allow),
      .prog_mode(pm), .hv_session(hvs), .lv_session(lvs), .tx_enable(tx_en),
      .tx_bit(tx_b), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rdy),
      .rx_overrun(ovr));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // consumer side: every popped word must be the oldest one sent
   always @(posedge ref_clk) begin
      if (rx_valid === 1'b1 && rdy === 1'b1)
         check(32'(rx_word), exp_q.size() ? 32'(exp_q.pop_front()) : 'x);
   end
   // single driver of rdy, so a mode change never races a random value
   always @(negedge ref_clk) begin
      if (rdy_rand) begin
         rdy <= 1'($urandom_range(0, 1));
      end else begin
         rdy <= rdy_hold;
      end
   end
   initial begin
      #500000;
      n_fail++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      en = 1'b0;
      set = 1'b0;
      clr_req = 1'b0;
      tx_en = 1'b0;
      tx_b = 1'b0;
      rdy_rand = 1'b0;
      rdy_hold = 1'b0;
      void'($urandom(32'hb0811b91));
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      i_prog.wait_n(4);
      check(oe_n, 1'b1);
      for (int i = 0; i < 4; i++) begin
         {en, set} = i[1:0];
         @(negedge ref_clk);
         check(rpe, i != 0);
      end
      {en, set} = 2'b00;
      i_prog.hv_enter(1'b1);
      check(hvs, 1'b0);
      i_prog.hv_leave();
      i_prog.hv_enter(1'b0);
      check({hvs, pm}, 2'b11);
      tx_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tx_b = 1'($urandom);
         clr_req = 1'($urandom);
         @(negedge ref_clk);
         check({oe_n, data_w}, {1'b0, tx_b});
         check(allow, clr_req);
      end
      clr_req = 1'b1;
      tx_en = 1'b0;
      i_prog.wait_n(2);
      check(allow, 1'b1);
      check(oe_n, 1'b1);
      i_prog.hv_leave();
      check({hvs, allow}, 2'b00);
      i_prog.reset_low();
      i_prog.send_key(KEY, 31, 0);
      i_prog.wait_n(4);
      check(lvs, 1'b0);
      i_prog.reset_high();
      en = 1'b1;
      // half a key, reset pulse, then the other half: must not match
      i_prog.reset_low();
      i_prog.send_key(KEY, 31, 16);
      i_prog.reset_high();
      i_prog.reset_low();
      i_prog.send_key(KEY, 15, 0);
      i_prog.wait_n(4);
      check(lvs, 1'b0);
      i_prog.reset_high();
      i_prog.reset_low();
      i_prog.send_key(KEY, 31, 0);
      i_prog.wait_n(4);
      check({lvs, pm, allow}, 3'b110);
      rdy_rand = 1'b1;
      for (int i = 0; i < 6; i++) begin
         w = WW'($urandom);
         exp_q.push_back(w);
         i_prog.send_word(w);
      end
      rdy_rand = 1'b0;
      rdy_hold = 1'b1;
      i_prog.wait_n(8);
      check(exp_q.size(), 0);
      // stall: two words fill the buffer, a third waits, one more bit is lost
      rdy_hold = 1'b0;
      for (int i = 0; i < 3; i++) begin
         w = WW'($urandom);
         exp_q.push_back(w);
         i_prog.send_word(w);
      end
      i_prog.send_bit(1'b1);
      i_prog.wait_n(4);
      check({rx_valid, ovr}, 2'b11);
      rdy_hold = 1'b1;
      i_prog.wait_n(12);
      check(exp_q.size(), 0);
      check(rx_valid, 1'b0);
      i_prog.reset_high();
      check({lvs, pm, ovr}, 3'b000);
      give_verdict();
   end
endmodule
